// file: msl_pkg.sv
// constants, widths and state encoding for the motor speed lock and protect block
// assumes a 20 MHz core clock and a reference clock well below it
package msl_pkg;

    // core clock
    localparam int CORE_CLK_HZ = 20_000_000;

    // speed loop: target feedback period in reference clock edges
    localparam int        REF_DIV        = 512;
    localparam int        LOCK_TOL_BP    = 625; // window in hundredths of a percent
    localparam int        PERIOD_W       = 10;
    localparam logic [9:0] TARGET_CNT    = 10'(REF_DIV);
    localparam logic [9:0] LOCK_TOL      = 10'(REF_DIV * LOCK_TOL_BP / 10000);
    localparam logic [9:0] PERIOD_MAX    = 10'h3FF;

    // drive duty
    localparam logic [7:0] DUTY_RESET    = 8'h80;
    localparam logic [7:0] DUTY_MAX      = 8'hFF;
    localparam int         ERR_SHIFT     = 2;

    // lock protection timer: one tick per millisecond
    localparam int TICK_TIME_US          = 1000;
    localparam int TICK_CYCLES           = CORE_CLK_HZ / 1_000_000 * TICK_TIME_US;
    localparam int TRIP_MS_PER_UNIT      = 330;
    localparam int DISCHARGE_MS_PER_UNIT = 15;
    localparam int TIMER_W               = 18;
    localparam logic [17:0] TRIP_PER_UNIT = 18'(TRIP_MS_PER_UNIT);
    localparam logic [17:0] DECAY_STEP    = 18'(TRIP_MS_PER_UNIT / DISCHARGE_MS_PER_UNIT);

    // dead time on a direction change
    localparam int         DEAD_TIME_NS  = 1000;
    localparam logic [7:0] DEAD_CYCLES   =
        8'((DEAD_TIME_NS * (CORE_CLK_HZ / 1_000_000) + 999) / 1000);

    // pin synchroniser: bit 0 stop, 1 dir, 2 feedback, 3 ref, 6:4 hall, 7 current limit
    localparam int         SYNC_W        = 8;
    localparam logic [7:0] SYNC_RESET    = 8'h01;

    typedef enum logic [1:0] {
        MSL_STOP,
        MSL_RUN,
        MSL_DEAD
    } msl_state_t;

endpackage

// file: msl_sync.sv
// two flip-flop synchroniser for the asynchronous pins of the block
// assumes the pins are slow next to the core clock
`timescale 1ns/1ps
`default_nettype none

module msl_sync (
    input  wire logic                       core_clk_in,
    input  wire logic                       rst_in,
    input  wire logic [msl_pkg::SYNC_W-1:0] async_in,
    output logic      [msl_pkg::SYNC_W-1:0] sync_out
);

    logic [msl_pkg::SYNC_W-1:0] stage1;
    logic [msl_pkg::SYNC_W-1:0] next_stage1;
    logic [msl_pkg::SYNC_W-1:0] next_sync;

    // first stage feeds only the second
    always_comb begin
        next_stage1 = async_in;
        next_sync   = stage1;
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            stage1   <= msl_pkg::SYNC_RESET;
            sync_out <= msl_pkg::SYNC_RESET;
        end else begin
            stage1   <= next_stage1;
            sync_out <= next_sync;
        end
    end

endmodule

`default_nettype wire

// file: msl_top.sv
// speed lock detection, duty regulation, lock protection and direction changeover
// assumes pins are asynchronous; lock_timer_setting_in is static configuration
//
// How it works
// - lock flag low within 6.25 percent of target
// - duty follows speed error outside the window
// - unlocked run for interval turns low sides off
// - trip holds until stop or power up
// - zero timer setting disables lock protection
// - timer decays gradually while stopped
// - direction pin selects commutation order
// - dead phase on direction change avoids shoot-through
// - overcurrent turns low sides off, high sides keep commutating
// - high stop pin means stop and power save
// - one error result per feedback cycle, target 512
`timescale 1ns/1ps
`default_nettype none

module msl_top #(
    parameter int TICK_CYCLES = msl_pkg::TICK_CYCLES
) (
    input  wire logic        core_clk_in,
    input  wire logic        rst_in,
    input  wire logic        stop_select_in,
    input  wire logic        dir_select_in,
    input  wire logic        speed_feedback_pulse_in,
    input  wire logic        ref_clk_in,
    input  wire logic [2:0]  hall_in,
    input  wire logic        current_limit_in,
    input  wire logic [7:0]  lock_timer_setting_in,
    output logic             speed_lock_flag_out,
    output logic [2:0]       high_side_out,
    output logic [2:0]       low_side_out,
    output logic             lock_trip_out,
    output logic             power_save_out,
    output logic [7:0]       duty_out,
    output logic [10:0]      speed_error_out
);

    ////////////////////////////////////////////////////////////////////////////////
    // pin synchronisation and edge detection

    logic [msl_pkg::SYNC_W-1:0] pins;
    logic                       fb_prev;
    logic                       ref_prev;
    logic                       stop_s;
    logic                       dir_s;
    logic                       fb_rise;
    logic                       ref_rise;
    logic [2:0]                 hall_s;
    logic                       ilim_s;

    msl_sync u_sync (
        .core_clk_in (core_clk_in),
        .rst_in      (rst_in),
        .async_in    ({current_limit_in, hall_in, ref_clk_in, speed_feedback_pulse_in,
                       dir_select_in, stop_select_in}),
        .sync_out    (pins)
    );

    // field split of the synchronised pins
    assign stop_s   = pins[0];
    assign dir_s    = pins[1];
    assign hall_s   = pins[6:4];
    assign ilim_s   = pins[7];
    assign fb_rise  = pins[2] & ~fb_prev;
    assign ref_rise = pins[3] & ~ref_prev;

    // previous levels for edge detection
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            fb_prev  <= 1'b0;
            ref_prev <= 1'b0;
        end else begin
            fb_prev  <= pins[2];
            ref_prev <= pins[3];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // speed measurement, lock window and duty regulation

    msl_pkg::msl_state_t state;
    msl_pkg::msl_state_t next_state;

    logic [9:0]         period_cnt;
    logic [9:0]         next_period_cnt;
    logic               seen_edge;
    logic               next_seen_edge;
    logic               locked;
    logic               next_locked;
    logic [7:0]         duty;
    logic [7:0]         next_duty;
    logic signed [10:0] speed_err;
    logic signed [10:0] next_speed_err;
    logic signed [10:0] meas_err;
    logic signed [10:0] duty_sum;
    logic               in_window;

    // one measurement per feedback period, counted in reference edges
    always_comb begin
        next_period_cnt = period_cnt;
        next_seen_edge  = seen_edge;
        next_locked     = locked;
        next_duty       = duty;
        next_speed_err  = speed_err;
        meas_err        = $signed({1'b0, period_cnt}) - $signed({1'b0, msl_pkg::TARGET_CNT});
        in_window       = (period_cnt >= msl_pkg::TARGET_CNT - msl_pkg::LOCK_TOL)
                       && (period_cnt <= msl_pkg::TARGET_CNT + msl_pkg::LOCK_TOL);
        duty_sum        = $signed({3'b000, duty}) + (meas_err >>> msl_pkg::ERR_SHIFT);
        if (state == msl_pkg::MSL_STOP) begin
            next_period_cnt = 10'h000;
            next_seen_edge  = 1'b0;
            next_locked     = 1'b0;
        end else if (fb_rise) begin
            next_period_cnt = ref_rise ? 10'h001 : 10'h000; // shared edge opens new period
            next_seen_edge  = 1'b1;
            if (seen_edge) begin
                next_speed_err = meas_err;
                next_locked    = in_window;
                if (!in_window) begin
                    // long period means slow: raise duty, short period lowers it
                    if (duty_sum < 11'sh000) begin
                        next_duty = 8'h00;
                    end else if (duty_sum > $signed({3'b000, msl_pkg::DUTY_MAX})) begin
                        next_duty = msl_pkg::DUTY_MAX;
                    end else begin
                        next_duty = duty_sum[7:0];
                    end
                end
            end
        end else if (period_cnt == msl_pkg::PERIOD_MAX) begin
            next_locked = 1'b0; // stalled motor never counts as locked
            next_duty   = msl_pkg::DUTY_MAX;
        end else if (ref_rise) begin
            next_period_cnt = period_cnt + 10'h001;
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            period_cnt <= 10'h000;
            seen_edge  <= 1'b0;
            locked     <= 1'b0;
            duty       <= msl_pkg::DUTY_RESET;
            speed_err  <= 11'sh000;
        end else begin
            period_cnt <= next_period_cnt;
            seen_edge  <= next_seen_edge;
            locked     <= next_locked;
            duty       <= next_duty;
            speed_err  <= next_speed_err;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // lock protection timer

    logic [31:0]                   tick_cnt;
    logic [31:0]                   next_tick_cnt;
    logic [msl_pkg::TIMER_W-1:0]   lock_timer;
    logic [msl_pkg::TIMER_W-1:0]   next_lock_timer;
    logic [msl_pkg::TIMER_W-1:0]   terminal;
    logic                          trip;
    logic                          next_trip;
    logic                          tick;

    // millisecond tick, timer count and trip latch
    always_comb begin
        tick            = (tick_cnt == 32'(TICK_CYCLES - 1));
        next_tick_cnt   = tick ? 32'h0000_0000 : tick_cnt + 32'h0000_0001;
        terminal        = 18'(msl_pkg::TRIP_PER_UNIT * {10'h000, lock_timer_setting_in});
        next_lock_timer = lock_timer;
        next_trip       = trip;
        if (state == msl_pkg::MSL_STOP) begin
            next_trip = 1'b0;
            if (tick) begin
                if (lock_timer > msl_pkg::DECAY_STEP) begin
                    next_lock_timer = lock_timer - msl_pkg::DECAY_STEP;
                end else begin
                    next_lock_timer = '0;
                end
            end
        end else if (locked) begin
            next_lock_timer = '0;
        end else begin
            if (tick && lock_timer < terminal) begin
                next_lock_timer = lock_timer + 18'h00001;
            end
            if (lock_timer >= terminal && lock_timer_setting_in != 8'h00) begin
                next_trip = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            tick_cnt   <= 32'h0000_0000;
            lock_timer <= '0;
            trip       <= 1'b0;
        end else begin
            tick_cnt   <= next_tick_cnt;
            lock_timer <= next_lock_timer;
            trip       <= next_trip;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // run state, direction changeover and phase drive

    logic       run_dir;
    logic       next_run_dir;
    logic [7:0] dead_cnt;
    logic [7:0] next_dead_cnt;
    logic [7:0] pwm_cnt;
    logic [5:0] comm;
    logic [2:0] next_high;
    logic [2:0] next_low;
    logic       next_lock_flag;

    // hall code to {high sides, low sides}; reverse swaps the two
    function automatic logic [5:0] commutate(input logic [2:0] hall, input logic rev);
        logic [5:0] fwd;
        fwd = 6'h00;
        unique case (hall)
            3'h1:    fwd = {3'h1, 3'h2};
            3'h3:    fwd = {3'h1, 3'h4};
            3'h2:    fwd = {3'h2, 3'h4};
            3'h6:    fwd = {3'h2, 3'h1};
            3'h4:    fwd = {3'h4, 3'h1};
            3'h5:    fwd = {3'h4, 3'h2};
            default: fwd = 6'h00; // invalid hall code: all off
        endcase
        return rev ? {fwd[2:0], fwd[5:3]} : fwd;
    endfunction

    // state transitions and drive outputs
    always_comb begin
        next_state     = state;
        next_run_dir   = run_dir;
        next_dead_cnt  = dead_cnt;
        next_high      = 3'h0;
        next_low       = 3'h0;
        next_lock_flag = ~next_locked;
        comm           = commutate(hall_s, run_dir);
        unique case (state)
            msl_pkg::MSL_STOP: begin
                if (!stop_s) begin
                    next_state   = msl_pkg::MSL_RUN;
                    next_run_dir = dir_s;
                end
            end
            msl_pkg::MSL_RUN: begin
                if (stop_s) begin
                    next_state = msl_pkg::MSL_STOP;
                end else if (dir_s != run_dir) begin
                    next_state    = msl_pkg::MSL_DEAD;
                    next_dead_cnt = msl_pkg::DEAD_CYCLES - 8'h01;
                end else begin
                    next_high = comm[5:3];
                    // low sides carry the pwm and all protection gating
                    if (!trip && !ilim_s && pwm_cnt < duty) begin
                        next_low = comm[2:0];
                    end
                end
            end
            msl_pkg::MSL_DEAD: begin
                if (stop_s) begin
                    next_state = msl_pkg::MSL_STOP;
                end else if (dead_cnt == 8'h00) begin
                    next_state   = msl_pkg::MSL_RUN;
                    next_run_dir = dir_s;
                end else begin
                    next_dead_cnt = dead_cnt - 8'h01;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state               <= msl_pkg::MSL_STOP;
            run_dir             <= 1'b0;
            dead_cnt            <= 8'h00;
            pwm_cnt             <= 8'h00;
            high_side_out       <= 3'h0;
            low_side_out        <= 3'h0;
            speed_lock_flag_out <= 1'b1;
        end else begin
            state               <= next_state;
            run_dir             <= next_run_dir;
            dead_cnt            <= next_dead_cnt;
            pwm_cnt             <= pwm_cnt + 8'h01;
            high_side_out       <= next_high;
            low_side_out        <= next_low;
            speed_lock_flag_out <= next_lock_flag;
        end
    end

    // status outputs straight from registers, power save decoded from the state register
    assign lock_trip_out   = trip;
    assign power_save_out  = (state == msl_pkg::MSL_STOP);
    assign duty_out        = duty;
    assign speed_error_out = speed_err;

endmodule

`default_nettype wire

// file: msl_motor_model.sv
// motor stand-in: free reference clock, feedback pulses, six-step hall code
// assumes the bench sets the feedback period in reference clock edges
`timescale 1ns/1ps
`default_nettype none
module msl_motor_model (
    input  wire logic        fb_en_in,
    input  wire logic [10:0] period_in,
    output logic             ref_clk_out,
    output logic             fb_out,
    output logic [2:0]       hall_out
);
    localparam logic [2:0] HALL [6] = '{3'h1, 3'h3, 3'h2, 3'h6, 3'h4, 3'h5};
    logic [10:0] cnt;
    logic [2:0]  step;
    // oscillator runs free, out of phase with the core clock
    initial begin
        ref_clk_out = 1'b0;
        cnt = 11'h000;
        step = 3'h0;
        fb_out = 1'b0;
        #13;
        forever #200 ref_clk_out = ~ref_clk_out;
    end
    // one pulse every period_in edges; hall moves on with each pulse
    always @(posedge ref_clk_out) begin
        fb_out <= 1'b0;
        if (fb_en_in) begin
            if (cnt >= period_in - 11'h001) begin
                cnt <= 11'h000;
                fb_out <= 1'b1;
                step <= (step == 3'h5) ? 3'h0 : step + 3'h1;
            end else begin
                cnt <= cnt + 11'h001;
            end
        end
    end
    assign hall_out = HALL[step]; // never 000 or 111
endmodule
`default_nettype wire

// file: msl_top_sva.sv
// port checker for msl_top
// assumes one core clock domain with active high reset
`timescale 1ns/1ps
`default_nettype none
module msl_top_sva (
    input wire logic        core_clk_in,
    input wire logic        rst_in,
    input wire logic        stop_select_in,
    input wire logic        dir_select_in,
    input wire logic        current_limit_in,
    input wire logic [7:0]  lock_timer_setting_in,
    input wire logic        speed_lock_flag_out,
    input wire logic [2:0]  high_side_out,
    input wire logic [2:0]  low_side_out,
    input wire logic        lock_trip_out,
    input wire logic        power_save_out,
    input wire logic [7:0]  duty_out,
    input wire logic [10:0] speed_error_out
);
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (rst_in);
    ////////////////////////////////////////
    property p_flag_stop;
        power_save_out && $past(power_save_out) |-> speed_lock_flag_out;
    endproperty
    a_flag_stop: assert property (p_flag_stop)
        else $error("lock flag low while stopped");
    property p_lock_win;
        $fell(speed_lock_flag_out) |-> ($signed(speed_error_out) >= -11'sd32)
            && ($signed(speed_error_out) <= 11'sd32);
    endproperty
    a_lock_win: assert property (p_lock_win)
        else $error("lock flag fell outside window");
    property p_duty_lock;
        !speed_lock_flag_out && !$past(speed_lock_flag_out) |-> $stable(duty_out);
    endproperty
    a_duty_lock: assert property (p_duty_lock)
        else $error("duty moved while locked");
    property p_no_shoot;
        (high_side_out & low_side_out) == 3'h0;
    endproperty
    a_no_shoot: assert property (p_no_shoot)
        else $error("high and low side on together");
    property p_dead;
        $changed(dir_select_in) && !power_save_out
            |-> ##[2:6] (high_side_out == 3'h0 && low_side_out == 3'h0);
    endproperty
    a_dead: assert property (p_dead)
        else $error("no dead phase on direction change");
    property p_trip_low;
        $past(lock_trip_out) && lock_trip_out |-> low_side_out == 3'h0;
    endproperty
    a_trip_low: assert property (p_trip_low)
        else $error("low side on after trip");
    property p_trip_hold;
        $past(lock_trip_out) && !$past(power_save_out) && !power_save_out |-> lock_trip_out;
    endproperty
    a_trip_hold: assert property (p_trip_hold)
        else $error("trip cleared outside stop");
    property p_trip_off;
        lock_timer_setting_in == 8'h00 |-> !$rose(lock_trip_out);
    endproperty
    a_trip_off: assert property (p_trip_off)
        else $error("trip with protection disabled");
    property p_cur_lim;
        current_limit_in [*4] |-> low_side_out == 3'h0;
    endproperty
    a_cur_lim: assert property (p_cur_lim)
        else $error("low side on during current limit");
    property p_stop_ps;
        stop_select_in [*5] |-> power_save_out;
    endproperty
    a_stop_ps: assert property (p_stop_ps)
        else $error("no power save with stop pin high");
endmodule
`default_nettype wire

// file: msl_top_tb.sv
// self-checking bench for msl_top driving a motor stand-in
// assumes TICK_CYCLES of 20, so the protection tick is one microsecond
`timescale 1ns/1ps
`default_nettype none
module msl_top_tb;
    logic        core_clk_in, rst_in, stop_select_in, dir_select_in, current_limit_in;
    logic [7:0]  lock_timer_setting_in, duty;
    logic        fb_en, ref_clk, fb, flag, trip, ps;
    logic [10:0] period, err;
    logic [2:0]  hall, hs, ls, ls_f;
    int          bad_count, checks, n;
    msl_motor_model u_msl_motor_model (.fb_en_in(fb_en), .period_in(period),
        .ref_clk_out(ref_clk), .fb_out(fb), .hall_out(hall));
    msl_top #(.TICK_CYCLES(20)) u_msl_top (.core_clk_in(core_clk_in), .rst_in(rst_in),
        .stop_select_in(stop_select_in), .dir_select_in(dir_select_in),
        .speed_feedback_pulse_in(fb), .ref_clk_in(ref_clk), .hall_in(hall),
        .current_limit_in(current_limit_in), .lock_timer_setting_in(lock_timer_setting_in),
        .speed_lock_flag_out(flag), .high_side_out(hs), .low_side_out(ls),
        .lock_trip_out(trip), .power_save_out(ps), .duty_out(duty), .speed_error_out(err));
    ////////////////////////////////////////
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(negedge core_clk_in);
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // bounded wait for the trip latch, n counts the cycles taken
    task automatic wait_trip(input int lim);
        n = 0;
        while (trip !== 1'b1 && n < lim) begin
            cyc(1);
            n++;
        end
        if (n >= lim) begin
            chk("trip wait", 16'h1, {15'h0, trip});
            summarize();
        end
    endtask
    // new feedback period, then wait for a clean result at it
    task automatic set_per(input logic [10:0] p);
        period = p;
        cyc(9900);
    endtask
    ////////////////////////////////////////
    task automatic t_lock();
        stop_select_in = 1'b0;
        set_per(11'd512);
        chk("ps run", 16'h0, {15'h0, ps});
        chk("flag 512", 16'h0, {15'h0, flag});
        chk("err 512", 16'h0, {5'h0, err});
        set_per(11'd480);
        chk("flag 480", 16'h0, {15'h0, flag});
        chk("err 480", 16'h07E0, {5'h0, err});
        set_per(11'd545);
        chk("flag 545", 16'h1, {15'h0, flag});
        chk("err 545", 16'h0021, {5'h0, err});
        chk("duty up", 16'h1, {15'h0, duty > 8'h80});
        chk("duty step", 16'h0, {13'h0, duty[2:0]});
        $display("lock test done");
    endtask
    task automatic t_dir();
        fb_en = 1'b0;
        cyc(8);
        ls_f = 3'h0;
        repeat (256) begin
            cyc(1);
            ls_f = ls_f | ls;
        end
        chk("fwd high", 16'h1, {15'h0, hs != 3'h0});
        dir_select_in = 1'b1;
        cyc(5);
        chk("dead", 16'h0, {10'h0, hs, ls});
        cyc(40);
        chk("rev high", {13'h0, ls_f}, {13'h0, hs});
        current_limit_in = 1'b1;
        cyc(4);
        chk("limit", {10'h0, ls_f, 3'h0}, {10'h0, hs, ls});
        current_limit_in = 1'b0;
        dir_select_in = 1'b0;
        cyc(40);
        cyc(8400);
        chk("stall duty", 16'h00FF, {8'h0, duty});
        chk("stall flag", 16'h1, {15'h0, flag});
        fb_en = 1'b1;
        $display("direction test done");
    endtask
    task automatic t_trip();
        period = 11'd600;
        wait_trip(25000);
        cyc(2);
        chk("trip low", 16'h0, {13'h0, ls});
        chk("trip high", 16'h1, {15'h0, hs != 3'h0});
        cyc(2000);
        chk("trip held", 16'h1, {15'h0, trip});
        stop_select_in = 1'b1;
        cyc(100);
        chk("trip cleared", 16'h0, {15'h0, trip});
        chk("ps stop", 16'h1, {15'h0, ps});
        stop_select_in = 1'b0;
        wait_trip(25000);
        chk("short restart", 16'h1, {15'h0, n > 1500 && n < 3000});
        stop_select_in = 1'b1;
        cyc(1100);
        stop_select_in = 1'b0;
        wait_trip(25000);
        chk("full restart", 16'h1, {15'h0, n > 19000});
        $display("trip test done");
    endtask
    task automatic t_off();
        rst_in = 1'b1;
        lock_timer_setting_in = 8'h00;
        cyc(3);
        rst_in = 1'b0;
        cyc(6000);
        chk("no trip", 16'h0, {15'h0, trip});
        $display("disable test done");
    endtask
    ////////////////////////////////////////
    initial begin
        core_clk_in = 1'b0;
        forever #25 core_clk_in = ~core_clk_in;
    end
    initial begin
        rst_in = 1'b1;
        stop_select_in = 1'b1;
        dir_select_in = 1'b0;
        current_limit_in = 1'b0;
        lock_timer_setting_in = 8'h03;
        fb_en = 1'b1;
        period = 11'd512;
        bad_count = 0;
        checks = 0;
        cyc(3);
        chk("reset out", 16'h0080, {8'h0, flag, hs, ls, trip});
        chk("reset duty", 16'h0180, {7'h0, ps, duty});
        rst_in = 1'b0;
        t_lock();
        t_dir();
        t_trip();
        t_off();
        summarize();
    end
endmodule
bind msl_top msl_top_sva u_msl_top_sva (.core_clk_in(core_clk_in), .rst_in(rst_in),
    .stop_select_in(stop_select_in), .dir_select_in(dir_select_in),
    .current_limit_in(current_limit_in), .lock_timer_setting_in(lock_timer_setting_in),
    .speed_lock_flag_out(speed_lock_flag_out), .high_side_out(high_side_out),
    .low_side_out(low_side_out), .lock_trip_out(lock_trip_out),
    .power_save_out(power_save_out), .duty_out(duty_out), .speed_error_out(speed_error_out));
`default_nettype wire
